// file: pkg/rmc_consts.svh
// Constants of the radio modem control block: command codes, reset values,
// divider codes and timing counts. Assumes a single 250 MHz core clock.
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH

// ----------------------------------------------------------------------
// Serial command codes
// ----------------------------------------------------------------------
`define RMC_OP_START_RX 8'h01
`define RMC_OP_START_TX 8'h02
`define RMC_OP_IDLE 8'h03
`define RMC_OP_FAST_RSSI 8'h04
`define RMC_OP_MODEM_STATUS 8'h05
`define RMC_OP_AMP_POWER 8'h06
`define RMC_OP_FRAC_HIGH 8'h07
`define RMC_OP_FRAC_MID 8'h08
`define RMC_OP_FRAC_LOW 8'h09
`define RMC_OP_INTEGER 8'h0a
`define RMC_OP_READ_FIFO 8'h0b
`define RMC_OP_WRITE_TX 8'h0c

// ----------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------
`define RMC_INTE_RST 8'h3c
`define RMC_FRAC_RST 20'h8_0001
`define RMC_CHAN_RST 8'h00
`define RMC_POWER_RST 7'h7f
`define RMC_BT_DEFAULT 4'h5
`define RMC_OUTDIV_LOW 4'hc
`define RMC_OUTDIV_MID 4'h8
`define RMC_OUTDIV_HIGH 4'h4
`define RMC_CRC_INIT 16'hffff
`define RMC_CRC_POLY 16'h1021
`define RMC_RSSI_OFFSET_DBM 130

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RMC_CLK_PERIOD_NS 4
`define RMC_RAMP_STEP_NS 100
`define RMC_RAMP_STEP_CYC ((`RMC_RAMP_STEP_NS + `RMC_CLK_PERIOD_NS - 1) / `RMC_CLK_PERIOD_NS)

`endif

// file: pkg/rmc_pkg.sv
// Types shared by the radio modem control block.
// Assumes the constants header is included by the design files.
package rmc_pkg;

  // Radio state, Gray coded along idle, ramp up, transmit, ramp down
  typedef enum logic [2:0] {
    RMC_IDLE = 3'b000,
    RMC_RAMP_UP = 3'b001,
    RMC_TX = 3'b011,
    RMC_RAMP_DOWN = 3'b010,
    RMC_RX = 3'b100
  } rmc_state_t;

  typedef logic [7:0] rmc_byte_t;

endpackage

// file: pkg/rmc_fifo_if.sv
// Carrier between the control core and its receive FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rmc_fifo_if #(parameter int W = 8, parameter int DEPTH = 64);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [$clog2(DEPTH):0] level;

  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data, level);
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, level);
endinterface

// file: src/rmc_fifo.sv
// Receive FIFO of the radio modem control block, flip-flop storage.
// Assumes one clock, active-low synchronous-release reset and a clock enable.
`timescale 1ns/1ps
module rmc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Queue ports
  rmc_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rmc_fifo: DEPTH must be a power of two, at least 4");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic do_push;
  logic do_pop;

  // Full and empty straight from the count
  assign q.push_ready = (count_q != AW'(0) + (AW+1)'(DEPTH));
  assign q.pop_valid = (count_q != '0);
  assign q.pop_data = mem_q[rd_ptr_q];
  assign q.level = count_q;
  assign do_push = q.push_valid && q.push_ready;
  assign do_pop = q.pop_ready && q.pop_valid;

  // Storage, one register per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in) begin
      if (ce_in && do_push && wr_ptr_q == AW'(i)) begin
        mem_q[i] <= q.push_data;
      end
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (ce_in) begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // rmc_fifo

// file: src/rmc_top.sv
// Control core of a half-duplex sub-GHz radio: serial command port,
// synthesizer word, channel, signal strength, CRC, amplifier ramp.
// Assumes the serial pins come from another clock domain; modem inputs and
// configuration pins are on core_clk_in.
`timescale 1ns/1ps
`include "rmc_consts.svh"
module rmc_top #(
  parameter int RX_FIFO_DEPTH = 64
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Serial command port
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Configuration
  input wire logic [1:0] band_sel_in,
  input wire logic [19:0] chan_step_in,
  input wire logic preamble_bypass_in,
  // Modem side
  input wire logic [7:0] rssi_live_in,
  input wire logic preamble_det_in,
  input wire logic sync_det_in,
  input wire logic rx_bit_in,
  input wire rmc_pkg::rmc_byte_t rx_byte_in,
  input wire logic rx_byte_valid_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  // Radio control
  output logic gpio_rx_data_out,
  output logic rx_active_out,
  output logic tx_active_out,
  output logic [6:0] pa_level_out,
  output logic [7:0] integer_divide_value_out,
  output logic [19:0] fractional_divide_value_out,
  output logic [3:0] outdiv_out,
  output logic [3:0] gauss_bt_out,
  output logic frac_invalid_out,
  // Transmit bytes and receive check
  output rmc_pkg::rmc_byte_t tx_byte_out,
  output logic tx_byte_valid_out,
  output logic crc_done_out,
  output logic crc_err_out
);
  import rmc_pkg::*;

  localparam int RAMP_CYC = `RMC_RAMP_STEP_CYC;
  if (RX_FIFO_DEPTH < 4) begin : g_bad_depth
    $error("rmc_top: RX_FIFO_DEPTH too small");
  end

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input rmc_byte_t b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `RMC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rst_s;
  logic rst_n;
  logic [2:0] sck_s;
  logic [2:0] cs_s;
  logic [1:0] mosi_s;

  // Assert at once, release after two edges
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s <= 2'b00;
    end else begin
      rst_s <= {rst_s[0], 1'b1};
    end
  end
  assign rst_n = rst_s[1];

  // Serial pins; edges are found on stages two and three only
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 3'b000;
      cs_s <= 3'b111;
      mosi_s <= 2'b00;
    end else if (ce_in) begin
      sck_s <= {sck_s[1:0], spi_sck_in};
      cs_s <= {cs_s[1:0], spi_cs_n_in};
      mosi_s <= {mosi_s[0], spi_mosi_in};
    end
  end

  logic cs_act, cs_start, cs_end, sck_rise, sck_fall;
  assign cs_act = !cs_s[1];
  assign cs_start = !cs_s[1] && cs_s[2];
  assign cs_end = cs_s[1] && !cs_s[2];
  assign sck_rise = cs_act && sck_s[1] && !sck_s[2];
  assign sck_fall = cs_act && !sck_s[1] && sck_s[2];

  // ----------------------------------------------------------------------
  // Serial byte framing
  // ----------------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] in_sr_q;
  logic [1:0] byte_idx_q;
  rmc_byte_t opcode_q, arg_q, in_byte, cur_op, resp;
  logic byte_done;
  logic [7:0] out_sr_q;
  rmc_state_t state_q;
  logic [7:0] rssi_latched_q, rssi_live_q;
  rmc_fifo_if #(.W(8), .DEPTH(RX_FIFO_DEPTH)) fq ();

  assign byte_done = sck_rise && bit_cnt_q == 3'h7;
  assign in_byte = {in_sr_q, mosi_s[1]};
  assign cur_op = (byte_idx_q == 2'h0) ? in_byte : opcode_q;

  // Mode 0: sample on rising, count bytes up to three plus
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 3'h0;
      in_sr_q <= 7'h00;
      byte_idx_q <= 2'h0;
      opcode_q <= 8'h00;
      arg_q <= 8'h00;
    end else if (ce_in) begin
      if (cs_start) begin
        bit_cnt_q <= 3'h0;
        byte_idx_q <= 2'h0;
      end else if (sck_rise) begin
        in_sr_q <= in_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_done) begin
          if (byte_idx_q != 2'h3) byte_idx_q <= byte_idx_q + 2'h1;
          if (byte_idx_q == 2'h0) opcode_q <= in_byte;
          if (byte_idx_q == 2'h1) arg_q <= in_byte;
        end
      end
    end
  end

  // Answer byte, ready at the opcode's last bit so one byte follows
  always_comb begin
    case (cur_op)
      `RMC_OP_FAST_RSSI: resp = rssi_latched_q;
      `RMC_OP_MODEM_STATUS: resp = rssi_live_q;
      `RMC_OP_READ_FIFO: resp = fq.pop_valid ? fq.pop_data : 8'h00;
      default: resp = 8'h00;
    endcase
  end
  assign fq.pop_ready = byte_done && cur_op == `RMC_OP_READ_FIFO;

  // Answer shifts out on falling edges, MSB first
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_sr_q <= 8'h00;
      spi_miso_out <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else if (ce_in) begin
      spi_miso_oe_out <= cs_act;
      if (cs_start) begin
        out_sr_q <= 8'h00;
      end else if (byte_done) begin
        out_sr_q <= resp;
      end else if (sck_fall) begin
        spi_miso_out <= out_sr_q[7];
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Synthesizer settings and channel
  // ----------------------------------------------------------------------
  logic [7:0] inte_q, chan_q;
  logic [19:0] frac_q;
  logic [6:0] pa_set_q;
  logic [27:0] freq_word;
  logic cmd_end, has_arg;
  assign cmd_end = cs_end && byte_idx_q != 2'h0;
  assign has_arg = byte_idx_q >= 2'h2;

  // Settings take effect at the end of the frame that carries them
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      inte_q <= `RMC_INTE_RST;
      frac_q <= `RMC_FRAC_RST;
      chan_q <= `RMC_CHAN_RST;
      pa_set_q <= `RMC_POWER_RST;
    end else if (ce_in && cmd_end && has_arg) begin
      case (opcode_q)
        `RMC_OP_START_RX, `RMC_OP_START_TX: chan_q <= arg_q;
        `RMC_OP_AMP_POWER: pa_set_q <= arg_q[6:0];
        `RMC_OP_FRAC_HIGH: frac_q[19:16] <= arg_q[3:0];
        `RMC_OP_FRAC_MID: frac_q[15:8] <= arg_q;
        `RMC_OP_FRAC_LOW: frac_q[7:0] <= arg_q;
        `RMC_OP_INTEGER: inte_q <= arg_q;
        default: chan_q <= chan_q;
      endcase
    end
  end

  // Base word plus channel times step; the ratio to RF is fixed by divider
  assign freq_word = {inte_q, frac_q} + 28'(chan_q) * 28'(chan_step_in);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      integer_divide_value_out <= `RMC_INTE_RST;
      fractional_divide_value_out <= `RMC_FRAC_RST;
      outdiv_out <= `RMC_OUTDIV_LOW;
      gauss_bt_out <= `RMC_BT_DEFAULT;
      frac_invalid_out <= 1'b0;
    end else if (ce_in) begin
      integer_divide_value_out <= freq_word[27:20];
      fractional_divide_value_out <= freq_word[19:0];
      gauss_bt_out <= `RMC_BT_DEFAULT;
      // Host must keep the fraction in range; flagged, not corrected
      frac_invalid_out <= !freq_word[19] || !freq_word[0];
      case (band_sel_in)
        2'h0: outdiv_out <= `RMC_OUTDIV_LOW;
        2'h1: outdiv_out <= `RMC_OUTDIV_MID;
        default: outdiv_out <= `RMC_OUTDIV_HIGH;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Radio state and amplifier ramp
  // ----------------------------------------------------------------------
  logic [$clog2(RAMP_CYC):0] ramp_cnt_q;
  logic ramp_tick, rx_entry, tx_side;
  assign ramp_tick = ramp_cnt_q == ($clog2(RAMP_CYC)+1)'(RAMP_CYC - 1);
  assign tx_side = state_q == RMC_RAMP_UP || state_q == RMC_TX;
  // A start-receive from idle or receive enters receive and restarts the latch
  assign rx_entry = cmd_end && opcode_q == `RMC_OP_START_RX && !tx_side
                    && state_q != RMC_RAMP_DOWN;

  // One shared oscillator: receive only from idle or receive, transmit ramps in and out
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RMC_IDLE;
      pa_level_out <= 7'h00;
      ramp_cnt_q <= '0;
    end else if (ce_in) begin
      ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 1'b1;
      case (state_q)
        RMC_RAMP_UP: begin
          if (pa_level_out == pa_set_q) state_q <= RMC_TX;
          else if (ramp_tick) pa_level_out <= pa_level_out + 7'h01;
        end
        RMC_RAMP_DOWN: begin
          if (pa_level_out == 7'h00) state_q <= RMC_IDLE;
          else if (ramp_tick) pa_level_out <= pa_level_out - 7'h01;
        end
        RMC_TX: begin
          if (pa_level_out != pa_set_q) state_q <= RMC_RAMP_UP;
        end
        default: ;
      endcase
      if (cmd_end) begin
        case (opcode_q)
          `RMC_OP_START_RX, `RMC_OP_IDLE: begin
            if (tx_side) state_q <= RMC_RAMP_DOWN;
            else if (rx_entry) state_q <= RMC_RX;
            else if (state_q == RMC_RX) state_q <= RMC_IDLE;
          end
          `RMC_OP_START_TX: begin
            if (!tx_side) state_q <= RMC_RAMP_UP;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_active_out <= 1'b0;
      tx_active_out <= 1'b0;
    end else if (ce_in) begin
      rx_active_out <= state_q == RMC_RX;
      tx_active_out <= state_q != RMC_RX && state_q != RMC_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Signal strength, acquisition and receive path
  // ----------------------------------------------------------------------
  logic pre_seen_q, synced_q, sync_hit, in_rx;
  logic [15:0] rx_crc_q, rx_crc_nx;
  assign in_rx = state_q == RMC_RX;
  assign sync_hit = in_rx && sync_det_in && (pre_seen_q || preamble_bypass_in);
  assign rx_crc_nx = crc_byte(rx_crc_q, rx_byte_in);
  assign fq.push_valid = in_rx && synced_q && rx_byte_valid_in;
  assign fq.push_data = rx_byte_in;

  // Code is passed in half-dB steps: dBm = code/2 - 130
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rssi_live_q <= 8'h00;
      rssi_latched_q <= 8'h00;
      pre_seen_q <= 1'b0;
      synced_q <= 1'b0;
    end else if (ce_in) begin
      rssi_live_q <= rssi_live_in;
      if (rx_entry) begin
        rssi_latched_q <= 8'h00;
        pre_seen_q <= 1'b0;
        synced_q <= 1'b0;
      end else if (sync_hit) begin
        rssi_latched_q <= rssi_live_in;
        synced_q <= 1'b1;
      end else if (in_rx && preamble_det_in) begin
        pre_seen_q <= 1'b1;
      end
      // A fresh sync in the closing cycle of a packet keeps capture open
      if (!in_rx || (synced_q && rx_byte_valid_in && rx_last_in && !sync_hit)) begin
        synced_q <= 1'b0;
        pre_seen_q <= 1'b0;
      end
    end
  end

  // Residue over payload plus received CRC is zero when clean
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_crc_q <= `RMC_CRC_INIT;
      crc_done_out <= 1'b0;
      crc_err_out <= 1'b0;
      gpio_rx_data_out <= 1'b0;
      rx_ready_out <= 1'b0;
    end else if (ce_in) begin
      gpio_rx_data_out <= in_rx && rx_bit_in;
      // Two slots of slack cover the one-cycle lag of this register
      rx_ready_out <= fq.level < ($clog2(RX_FIFO_DEPTH)+1)'(RX_FIFO_DEPTH - 2);
      crc_done_out <= 1'b0;
      if (sync_hit) begin
        rx_crc_q <= `RMC_CRC_INIT;
      end else if (fq.push_valid) begin
        rx_crc_q <= rx_crc_nx;
        if (rx_last_in) begin
          crc_done_out <= 1'b1;
          crc_err_out <= rx_crc_nx != 16'h0000;
        end
      end
    end
  end

  rmc_fifo #(.W(8), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .q(fq.store)
  );

  // ----------------------------------------------------------------------
  // Transmit bytes with appended CRC
  // ----------------------------------------------------------------------
  logic [15:0] tx_crc_q;
  logic [1:0] app_q;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_crc_q <= `RMC_CRC_INIT;
      app_q <= 2'h0;
      tx_byte_out <= 8'h00;
      tx_byte_valid_out <= 1'b0;
    end else if (ce_in) begin
      tx_byte_valid_out <= 1'b0;
      if (cs_start) begin
        tx_crc_q <= `RMC_CRC_INIT;
      end else if (byte_done && state_q == RMC_TX && byte_idx_q != 2'h0
                   && opcode_q == `RMC_OP_WRITE_TX) begin
        tx_byte_out <= in_byte;
        tx_byte_valid_out <= 1'b1;
        tx_crc_q <= crc_byte(tx_crc_q, in_byte);
      end else if (cs_end && has_arg && opcode_q == `RMC_OP_WRITE_TX
                   && state_q == RMC_TX) begin
        app_q <= 2'h2;
      end else if (app_q != 2'h0) begin
        tx_byte_out <= app_q[1] ? tx_crc_q[15:8] : tx_crc_q[7:0];
        tx_byte_valid_out <= 1'b1;
        app_q <= app_q - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n || !ce_in);

  property p_fast_rssi;
    (byte_done && cur_op == `RMC_OP_FAST_RSSI) |=> out_sr_q == $past(rssi_latched_q);
  endproperty
  a_fast_rssi: assert property (p_fast_rssi) else $error("fast answer wrong");
  property p_status;
    (byte_done && cur_op == `RMC_OP_MODEM_STATUS) |=> out_sr_q == $past(rssi_live_q);
  endproperty
  a_status: assert property (p_status) else $error("status answer wrong");
  property p_latch;
    sync_hit && !rx_entry |=> rssi_latched_q == $past(rssi_live_in);
  endproperty
  a_latch: assert property (p_latch) else $error("sync latch missed");
  property p_hold;
    !$past(sync_hit) && !$past(rx_entry) |-> $stable(rssi_latched_q);
  endproperty
  a_hold: assert property (p_hold) else $error("latched value moved");
  property p_chan_keep;
    (cmd_end && !has_arg && opcode_q == `RMC_OP_START_RX) |=> $stable(chan_q);
  endproperty
  a_chan_keep: assert property (p_chan_keep) else $error("channel lost");
  property p_band;
    (band_sel_in == 2'h1) |=> outdiv_out == `RMC_OUTDIV_MID;
  endproperty
  a_band: assert property (p_band) else $error("divider wrong");
  property p_duplex;
    !(rx_active_out && tx_active_out);
  endproperty
  a_duplex: assert property (p_duplex) else $error("rx and tx together");
  sequence s_ramp_step;
    state_q == RMC_RAMP_UP && ramp_tick && pa_level_out != pa_set_q;
  endsequence
  property p_ramp;
    s_ramp_step |=> pa_level_out == $past(pa_level_out) + 7'h01;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step wrong");
  sequence s_app_start;
    cs_end && has_arg && opcode_q == `RMC_OP_WRITE_TX && state_q == RMC_TX;
  endsequence
  property p_append;
    s_app_start |=> ##1 tx_byte_valid_out && tx_byte_out == $past(tx_crc_q[15:8], 2);
  endproperty
  a_append: assert property (p_append) else $error("crc not appended");
endmodule // rmc_top

// file: tb/rmc_host_model.sv
// Host side of the serial command port: mode 0 frames, 64 ns bit time.
// Assumes the bench pulls the answer line high while it is not driven.
`timescale 1ns/1ps
module rmc_host_model (
  // Serial pins
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  // Answer byte of the second frame byte
  output logic [7:0] rsp_out,
  output logic rsp_stb_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rsp_out = 8'h00;
    rsp_stb_out = 1'b0;
  end
  // Clock only runs inside a frame; data goes stale once cs rises
  task automatic frame(input int n, input logic [15:0] d, input bit want);
    int i;
    cs_n_out = 1'b0;
    #100;
    for (i = 0; i < 8 * n; i++) begin
      mosi_out = d[15-i];
      #32 sck_out = 1'b1;
      rsp_out = {rsp_out[6:0], miso_in};
      #32 sck_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #100 rsp_stb_out = want;
    #4 rsp_stb_out = 1'b0;
  endtask
endmodule // rmc_host_model

// file: tb/rmc_top_bench.sv
// Self-checking bench of the radio control core, host model on the serial port.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "rmc_consts.svh"
module rmc_top_bench;
  logic clk = 0, rstn = 0, pre = 0, syn = 0, byp = 0, bit_r = 0;
  logic [1:0] band = 0;
  logic [19:0] step = 0;
  logic [7:0] live = 0, rsp;
  logic [3:0] odt [4] = '{4'hc, 4'h8, 4'h4, 4'h4};
  logic [31:0] exp_q [$];
  int fail_count = 0, check_count = 0, b;
  wire sck, csn, mosi, so, soe, stb, rxa, txa;
  wire miso = soe ? so : 1'b1;
  wire [7:0] inte;
  wire [19:0] frac;
  wire [3:0] odiv, bt;
  logic rxv = 0, rxl = 0;
  logic [7:0] rxb = 0, pb;
  logic [7:0] pkt [4];
  logic [31:0] crc_q [$], tx_q [$];
  wire gpo, rrdy, finv, cdone, cerr, txv;
  wire [6:0] pa;
  wire [7:0] txb;
  always #2 clk = ~clk;
  rmc_host_model host (.sck_out(sck), .cs_n_out(csn), .mosi_out(mosi), .miso_in(miso),
    .rsp_out(rsp), .rsp_stb_out(stb));
  rmc_top #(.RX_FIFO_DEPTH(16)) i_dut (.core_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1),
    .spi_sck_in(sck), .spi_cs_n_in(csn), .spi_mosi_in(mosi), .spi_miso_out(so),
    .spi_miso_oe_out(soe), .band_sel_in(band), .chan_step_in(step),
    .preamble_bypass_in(byp), .rssi_live_in(live), .preamble_det_in(pre),
    .sync_det_in(syn), .rx_bit_in(bit_r), .rx_byte_in(rxb), .rx_byte_valid_in(rxv),
    .rx_last_in(rxl), .rx_ready_out(rrdy), .gpio_rx_data_out(gpo), .rx_active_out(rxa),
    .tx_active_out(txa), .pa_level_out(pa), .integer_divide_value_out(inte),
    .fractional_divide_value_out(frac), .outdiv_out(odiv), .gauss_bt_out(bt),
    .frac_invalid_out(finv), .tx_byte_out(txb), .tx_byte_valid_out(txv), .crc_done_out(cdone),
    .crc_err_out(cerr));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    // A result that never showed up leaves its note behind
    if (exp_q.size() + crc_q.size() + tx_q.size() != 0) fail_count++;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each answer byte is matched against the oldest note
  always @(posedge stb) chk({24'h0, rsp}, exp_q.pop_front());
  // One-cycle modem pulse driven off the sampling edge
  task pulse(input bit s);
    @(negedge clk);
    if (s) syn = 1; else pre = 1;
    @(negedge clk);
    syn = 0;
    pre = 0;
  endtask
  // Reference CRC over one byte, MSB first, from the polynomial constant
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) r = r[15] ? ((r << 1) ^ `RMC_CRC_POLY) : (r << 1);
    return r;
  endfunction
  // One packet after a sync: two payload bytes, then CRC high and low
  task rx_pkt(input bit bad);
    logic [15:0] c;
    pkt[0] = $urandom;
    pkt[1] = $urandom;
    c = crc_ref(crc_ref(`RMC_CRC_INIT, pkt[0]), pkt[1]);
    pkt[2] = c[15:8];
    pkt[3] = c[7:0] ^ {7'h00, bad};
    crc_q.push_back(bad);
    pulse(1);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      rxb = pkt[k];
      rxv = 1;
      rxl = k == 3;
    end
    @(negedge clk);
    rxv = 0;
    rxl = 0;
  endtask
  // Check verdicts and transmit bytes are one-cycle pulses, read mid-cycle
  always @(negedge clk) if (cdone) chk(cerr, crc_q.pop_front());
  always @(negedge clk) if (txv) chk(txb, tx_q.pop_front());
  initial begin
    #100000 fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hf56f));
    // Even step keeps the fraction's low bit for every channel, and its top bit for channel 5
    step = $urandom & 20'h00ffe;
    live = $urandom;
    bit_r = $urandom;
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1;
    repeat (5) @(negedge clk);
    chk({inte, frac}, 28'h3c8_0001);
    host.frame(2, 16'h0105, 0);
    chk({inte, frac}, 28'h3c8_0001 + 5 * step);
    host.frame(1, 16'h0100, 0);
    chk({inte, frac}, 28'h3c8_0001 + 5 * step);
    chk({rxa, txa}, 2'b10);
    for (b = 0; b < 4; b++) begin
      @(negedge clk) band = b;
      repeat (3) @(negedge clk);
      chk(odiv, odt[b]);
    end
    chk(bt, 4'h5);
    pulse(0);
    pulse(1);
    repeat (3) @(negedge clk);
    exp_q.push_back(live);
    live = live ^ 8'h5a;
    host.frame(2, 16'h0400, 1);
    exp_q.push_back(live);
    host.frame(2, 16'h0500, 1);
    host.frame(1, 16'h0100, 0);
    byp = 1;
    pulse(1);
    repeat (3) @(negedge clk);
    exp_q.push_back(live);
    host.frame(2, 16'h0400, 1);
    @(negedge clk) bit_r = ~bit_r;
    @(negedge clk) chk({finv, rrdy, gpo}, {2'b01, bit_r});
    host.frame(2, 16'h0902, 0);
    chk({finv, inte, frac}, {1'b1, 28'h3c8_0002 + 28'(5 * step)});
    host.frame(2, 16'h0903, 0);
    chk({finv, inte, frac}, {1'b0, 28'h3c8_0003 + 28'(5 * step)});
    rx_pkt(0);
    exp_q.push_back(pkt[0]);
    host.frame(2, 16'h0b00, 1);
    exp_q.push_back(pkt[2]);
    host.frame(2, 16'h0b00, 1);
    rx_pkt(1);
    host.frame(2, 16'h0603, 0);
    host.frame(1, 16'h0200, 0);
    repeat (150) @(negedge clk);
    chk({rxa, txa, pa}, {2'b01, 7'h03});
    pb = $urandom;
    tx_q.push_back(pb);
    tx_q.push_back(crc_ref(`RMC_CRC_INIT, pb) >> 8);
    tx_q.push_back(crc_ref(`RMC_CRC_INIT, pb) & 16'h00ff);
    host.frame(2, {8'h0c, pb}, 0);
    host.frame(1, 16'h0300, 0);
    repeat (150) @(negedge clk);
    chk({rxa, txa, pa}, 9'h000);
    wrap_up();
  end
endmodule // rmc_top_bench
